// ===== rtl/debug_port_defines.svh
/*
  Offsets, field positions, reset values and link framing constants for
  the two-wire debug port register selection block.
  Assumes inclusion by bare name from the design file and the bench.
*/
`ifndef DEBUG_PORT_DEFINES_SVH
`define DEBUG_PORT_DEFINES_SVH

// ----------------------------------------------------------------------
// Target select values
// ----------------------------------------------------------------------
`define SEL_PART_IDENTITY 8'h00
`define SEL_SILICON_REVISION 8'h01
`define SEL_DEVICE_CONTROL 8'h02
`define SEL_EPROM_PROGRAM_CONTROL 8'hDF
`define SEL_EPROM_DATA 8'hBF
`define SEL_EPROM_STATUS 8'hB7
`define SEL_EPROM_ADDRESS_HIGH 8'hAF
`define SEL_EPROM_ADDRESS_LOW 8'hAE
`define SEL_CHECKSUM_BYTE_0 8'hA9
`define SEL_CHECKSUM_BYTE_1 8'hAA
`define SEL_CHECKSUM_BYTE_2 8'hAB
`define SEL_CHECKSUM_BYTE_3 8'hAC

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define SELECT_RESET 8'h00
`define REG_RESET 8'h00
`define BUSY_BIT 7
`define HALT_BIT 0
`define PROGRAM_ENABLE_BIT 0
`define WRITE_LOCKED_BIT 7
`define READ_LOCKED_BIT 6
`define ERROR_BIT 0

// ----------------------------------------------------------------------
// Link framing and identity defaults
// ----------------------------------------------------------------------
`define CMD_BITS 3'h1
`define DATA_BITS 3'h7
`define PART_IDENTITY_DEFAULT 8'h5A
`define SILICON_REVISION_DEFAULT 8'h03

`endif

// ===== rtl/debug_port_pkg.sv
/*
  Types shared by the debug port register selection block.
  Assumes nothing of its surroundings.
*/
package debug_port_pkg;

  typedef enum logic [5:0] {
    LINK_IDLE = 6'h01,
    LINK_CMD = 6'h02,
    LINK_DATA = 6'h04,
    LINK_WAIT = 6'h08,
    LINK_READY = 6'h10,
    LINK_SEND = 6'h20
  } link_state_t;

  typedef enum logic [1:0] {
    CMD_DATA_READ = 2'h0,
    CMD_ADDR_READ = 2'h1,
    CMD_DATA_WRITE = 2'h2,
    CMD_ADDR_WRITE = 2'h3
  } link_cmd_t;

endpackage

// ===== rtl/debug_register_select.sv
/*
  Register selection front end of the two-wire debug port: link framing on
  the link clock, target select and data registers on the core clock.
  Assumes the adapter clocks the link only during frames, drives the data
  line except while this end's output enable is high, and that the EPROM
  controller answers each request with one done pulse.
*/
`timescale 1ns/1ps
`include "debug_port_defines.svh"

module debug_register_select #(
  parameter logic [7:0] PART_IDENTITY = `PART_IDENTITY_DEFAULT, // Arbitrary
  parameter logic [7:0] SILICON_REVISION = `SILICON_REVISION_DEFAULT // Arb.
) (
  input wire logic clk_in, // Core clock, 40 MHz
  input wire logic rst_in, // Asynchronous reset, active high
  input wire logic ce_in, // Core clock enable
  input wire logic debug_clock_line_in, // Link clock from adapter
  input wire logic debug_data_line_in, // Data line level
  output logic debug_data_line_out, // Data line drive value
  output logic debug_data_line_oe_out, // Data line drive enable
  output logic halt_out, // Processor halt request
  output logic eprom_read_out, // EPROM read start pulse
  output logic eprom_write_out, // EPROM write start pulse
  output logic [15:0] eprom_address_out, // EPROM address
  output logic [7:0] eprom_wdata_out, // EPROM write data
  input wire logic eprom_done_in, // EPROM operation finished
  input wire logic eprom_refused_in, // Finished operation was refused
  input wire logic [7:0] eprom_rdata_in, // EPROM read data with done
  input wire logic write_locked_flag_in, // Current address write-locked
  input wire logic read_locked_flag_in // Current address read-locked
);

  // --------------------------------------------------------------------
  // Link domain: frame capture and reply
  // --------------------------------------------------------------------
  debug_port_pkg::link_state_t lstate;
  logic [2:0] bit_cnt;
  logic [1:0] lcmd;
  logic [7:0] lwdata, lrdata, rd_word;
  logic req_tgl, ack_meta, ack_sync, ack_seen, ack_tgl, is_write;

  assign is_write = lcmd[1];
  always_ff @(posedge debug_clock_line_in or posedge rst_in) begin
    if (rst_in) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else begin
      ack_meta <= ack_tgl;
      ack_sync <= ack_meta;
    end
  end

  always_ff @(posedge debug_clock_line_in or posedge rst_in) begin
    if (rst_in) begin
      lstate <= debug_port_pkg::LINK_IDLE;
      bit_cnt <= 3'h0;
      lcmd <= 2'h0;
      lwdata <= 8'h00;
      lrdata <= 8'h00;
      req_tgl <= 1'b0;
      ack_seen <= 1'b0;
      debug_data_line_out <= 1'b0;
      debug_data_line_oe_out <= 1'b0;
    end else begin
      case (lstate)
        debug_port_pkg::LINK_IDLE: begin
          debug_data_line_oe_out <= 1'b0;
          bit_cnt <= 3'h0;
          if (debug_data_line_in) begin
            lstate <= debug_port_pkg::LINK_CMD;
          end
        end
        debug_port_pkg::LINK_CMD: begin
          lcmd <= {debug_data_line_in, lcmd[1]};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == `CMD_BITS) begin
            bit_cnt <= 3'h0;
            if (debug_data_line_in) begin
              lstate <= debug_port_pkg::LINK_DATA;
            end else begin
              req_tgl <= ~req_tgl;
              lstate <= debug_port_pkg::LINK_WAIT;
            end
          end
        end
        debug_port_pkg::LINK_DATA: begin
          lwdata <= {debug_data_line_in, lwdata[7:1]};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == `DATA_BITS) begin
            bit_cnt <= 3'h0;
            req_tgl <= ~req_tgl;
            lstate <= debug_port_pkg::LINK_WAIT;
          end
        end
        debug_port_pkg::LINK_WAIT: begin
          if (ack_sync != ack_seen) begin
            ack_seen <= ack_sync;
            lrdata <= rd_word;
            debug_data_line_out <= 1'b1;
            debug_data_line_oe_out <= 1'b1;
            lstate <= debug_port_pkg::LINK_READY;
          end
        end
        debug_port_pkg::LINK_READY: begin
          if (is_write) begin
            debug_data_line_oe_out <= 1'b0;
            lstate <= debug_port_pkg::LINK_IDLE;
          end else begin
            debug_data_line_out <= lrdata[0];
            lrdata <= {1'b0, lrdata[7:1]};
            lstate <= debug_port_pkg::LINK_SEND;
          end
        end
        debug_port_pkg::LINK_SEND: begin
          bit_cnt <= bit_cnt + 3'h1;
          debug_data_line_out <= lrdata[0];
          lrdata <= {1'b0, lrdata[7:1]};
          if (bit_cnt == `DATA_BITS) begin
            bit_cnt <= 3'h0;
            debug_data_line_oe_out <= 1'b0;
            lstate <= debug_port_pkg::LINK_IDLE;
          end
        end
        default: begin
          debug_data_line_oe_out <= 1'b0;
          lstate <= debug_port_pkg::LINK_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Core domain: request crossing
  // --------------------------------------------------------------------
  logic req_meta, req_sync, req_prev, req_evt;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_prev <= 1'b0;
    end else if (ce_in) begin
      req_meta <= req_tgl;
      req_sync <= req_meta;
      req_prev <= req_sync;
    end
  end

  // Command and write data stay still in the link domain until acknowledged
  assign req_evt = ce_in && (req_sync != req_prev);

  // --------------------------------------------------------------------
  // Core domain: registers
  // --------------------------------------------------------------------
  logic [7:0] select, debug_device_control, eprom_program_control, eprom_data, epaddr_h, epaddr_l;
  logic [7:0] crc [4];
  logic ep_busy, ep_error, ep_reading, launch_ok, data_wr, data_rd;
  logic launch_rd, launch_wr;
  logic [7:0] eprom_status, status_byte, next_rd_word;

  assign data_wr = req_evt && (lcmd == debug_port_pkg::CMD_DATA_WRITE);
  assign data_rd = req_evt && (lcmd == debug_port_pkg::CMD_DATA_READ);
  assign launch_ok = debug_device_control[`HALT_BIT] && eprom_program_control[`PROGRAM_ENABLE_BIT]
    && !ep_busy;
  assign launch_wr = data_wr && (select == `SEL_EPROM_DATA) && launch_ok;
  assign launch_rd = data_rd && (select == `SEL_EPROM_DATA) && launch_ok;
  assign eprom_status = {write_locked_flag_in, read_locked_flag_in, 5'h00,
    ep_error};
  assign status_byte = {ep_busy, 7'h00};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      select <= `SELECT_RESET;
    end else if (req_evt && lcmd == debug_port_pkg::CMD_ADDR_WRITE) begin
      select <= lwdata;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      debug_device_control <= `REG_RESET;
      eprom_program_control <= `REG_RESET;
      epaddr_h <= `REG_RESET;
      epaddr_l <= `REG_RESET;
      crc <= '{default: `REG_RESET};
    end else if (data_wr) begin
      case (select)
        `SEL_DEVICE_CONTROL: debug_device_control <= lwdata;
        `SEL_EPROM_PROGRAM_CONTROL: eprom_program_control <= lwdata;
        `SEL_EPROM_ADDRESS_HIGH: epaddr_h <= lwdata;
        `SEL_EPROM_ADDRESS_LOW: epaddr_l <= lwdata;
        `SEL_CHECKSUM_BYTE_0: crc[0] <= lwdata;
        `SEL_CHECKSUM_BYTE_1: crc[1] <= lwdata;
        `SEL_CHECKSUM_BYTE_2: crc[2] <= lwdata;
        `SEL_CHECKSUM_BYTE_3: crc[3] <= lwdata;
        default: debug_device_control <= debug_device_control;
      endcase
    end
  end

  // EPROM data: link writes it, a finished read that is not refused overwrites it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      eprom_data <= `REG_RESET;
    end else if (ce_in) begin
      if (ep_busy && ep_reading && eprom_done_in && !eprom_refused_in) begin
        eprom_data <= eprom_rdata_in;
      end else if (data_wr && select == `SEL_EPROM_DATA && !ep_busy) begin
        eprom_data <= lwdata;
      end
    end
  end

  // Busy and error; a launch waits for idle so set and clear never meet
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ep_busy <= 1'b0;
      ep_error <= 1'b0;
      ep_reading <= 1'b0;
      eprom_read_out <= 1'b0;
      eprom_write_out <= 1'b0;
    end else if (ce_in) begin
      eprom_read_out <= launch_rd;
      eprom_write_out <= launch_wr;
      if (launch_rd || launch_wr) begin
        ep_busy <= 1'b1;
        ep_reading <= launch_rd;
      end else if (ep_busy && eprom_done_in) begin
        ep_busy <= 1'b0;
        ep_error <= eprom_refused_in;
      end
    end
  end

  assign halt_out = debug_device_control[`HALT_BIT];
  assign eprom_address_out = {epaddr_h, epaddr_l};
  assign eprom_wdata_out = eprom_data;

  // --------------------------------------------------------------------
  // Core domain: read answer and acknowledge
  // --------------------------------------------------------------------
  always_comb begin
    next_rd_word = 8'h00;
    if (lcmd == debug_port_pkg::CMD_ADDR_READ) begin
      next_rd_word = status_byte;
    end else begin
      case (select)
        `SEL_PART_IDENTITY: next_rd_word = PART_IDENTITY;
        `SEL_SILICON_REVISION: next_rd_word = SILICON_REVISION;
        `SEL_DEVICE_CONTROL: next_rd_word = debug_device_control;
        `SEL_EPROM_PROGRAM_CONTROL: next_rd_word = eprom_program_control;
        `SEL_EPROM_DATA: next_rd_word = eprom_data;
        `SEL_EPROM_STATUS: next_rd_word = eprom_status;
        `SEL_EPROM_ADDRESS_HIGH: next_rd_word = epaddr_h;
        `SEL_EPROM_ADDRESS_LOW: next_rd_word = epaddr_l;
        `SEL_CHECKSUM_BYTE_0: next_rd_word = crc[0];
        `SEL_CHECKSUM_BYTE_1: next_rd_word = crc[1];
        `SEL_CHECKSUM_BYTE_2: next_rd_word = crc[2];
        `SEL_CHECKSUM_BYTE_3: next_rd_word = crc[3];
        default: next_rd_word = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_word <= 8'h00;
      ack_tgl <= 1'b0;
    end else if (req_evt) begin
      rd_word <= next_rd_word;
      ack_tgl <= ~ack_tgl;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_select_write: assert property (@(posedge clk_in)
    disable iff (rst_in) req_evt && lcmd == debug_port_pkg::CMD_ADDR_WRITE
    |=> select == $past(lwdata))
    else $error("select not loaded by address write");
  a_status_read: assert property (@(posedge clk_in)
    disable iff (rst_in) req_evt && lcmd == debug_port_pkg::CMD_ADDR_READ
    |=> rd_word == {$past(ep_busy), 7'h00} && ack_tgl != $past(ack_tgl))
    else $error("address read did not return status");
  a_ident_read: assert property (@(posedge clk_in)
    disable iff (rst_in) data_rd && select == `SEL_PART_IDENTITY
    |=> rd_word == PART_IDENTITY)
    else $error("part identity read wrong");
  a_revision_fixed: assert property (@(posedge clk_in)
    disable iff (rst_in) data_rd && select == `SEL_SILICON_REVISION
    |=> rd_word == SILICON_REVISION)
    else $error("silicon revision read wrong");
  a_busy_launch: assert property (@(posedge clk_in)
    disable iff (rst_in) launch_rd || launch_wr
    |=> ep_busy && (eprom_read_out || eprom_write_out)
    ##1 !eprom_read_out && !eprom_write_out)
    else $error("launch did not raise busy with one pulse");
  a_busy_hold: assert property (@(posedge clk_in)
    disable iff (rst_in) ep_busy && !eprom_done_in |=> ep_busy)
    else $error("busy dropped without done");
  a_busy_clear: assert property (@(posedge clk_in)
    disable iff (rst_in) ep_busy && eprom_done_in && ce_in
    |=> !ep_busy && ep_error == $past(eprom_refused_in))
    else $error("done did not clear busy or set error");
  a_halt_write: assert property (@(posedge clk_in)
    disable iff (rst_in) data_wr && select == `SEL_DEVICE_CONTROL
    |=> halt_out == $past(lwdata[`HALT_BIT]))
    else $error("halt does not follow device control");
  a_ready_drive: assert property (@(posedge debug_clock_line_in)
    disable iff (rst_in) lstate == debug_port_pkg::LINK_READY
    |-> debug_data_line_oe_out && debug_data_line_out)
    else $error("ready bit not driven");
  c_select_write: cover property (@(posedge clk_in) disable iff (rst_in)
    req_evt && lcmd == debug_port_pkg::CMD_ADDR_WRITE);
  c_eprom_cycle: cover property (@(posedge clk_in) disable iff (rst_in)
    launch_wr ##[1:300] ep_busy && eprom_done_in);
  c_read_reply: cover property (@(posedge debug_clock_line_in)
    disable iff (rst_in) lstate == debug_port_pkg::LINK_SEND);

endmodule // debug_register_select

// ===== bench/debug_adapter_model.sv
/*
  Behavioural programming adapter for the two-wire debug port.
  Assumes the bench resolves the shared data line and feeds it back.
*/
`timescale 1ns/1ps

module debug_adapter_model (
  output logic link_clk_out, // Link clock, runs only within frames
  output logic data_out, // Data drive value
  output logic data_oe_out, // Data drive enable
  input wire logic line_in, // Resolved data line
  input wire logic dev_oe_in // Device drive enable
);
  logic smp;
  logic smp_oe;

  initial begin
    link_clk_out = 1'b0;
    data_out = 1'b0;
    data_oe_out = 1'b0;
  end

  // One link cycle; the adapter moves data only while the clock is low, the device on the rising edge
  task automatic pulse();
    #80 link_clk_out = 1'b1;
    #1 smp = line_in;
    smp_oe = dev_oe_in;
    #79 link_clk_out = 1'b0;
  endtask

  task automatic send(input logic b);
    data_out = b;
    data_oe_out = 1'b1;
    pulse();
  endtask

  // Start bit, command, optional byte, wait for ready, answer
  task automatic frame(input logic [1:0] cmd, input logic [7:0] wd,
                       output logic [7:0] rd, output bit ok);
    int n;
    send(1'b1);
    for (int i = 0; i < 2; i++) begin
      send(cmd[i]);
    end
    if (cmd[1]) begin
      for (int i = 0; i < 8; i++) begin
        send(wd[i]);
      end
    end
    data_oe_out = 1'b0;
    ok = 1'b0;
    n = 0;
    while (!ok && n < 20) begin
      pulse();
      ok = smp_oe && smp;
      n++;
    end
    rd = 8'h00;
    if (ok && !cmd[1]) begin
      for (int i = 0; i < 8; i++) begin
        pulse();
        rd[i] = smp;
      end
    end
    pulse();
  endtask
endmodule // debug_adapter_model

// ===== bench/two_wire_debug_register_select_tb.sv
/*
  Self-checking bench for the debug port register selection block.
  Assumes the adapter model and an EPROM responder built in here.
*/
`timescale 1ns/1ps
`include "debug_port_defines.svh"

`define CHK(what, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end

module two_wire_debug_register_select_tb;
  localparam logic [7:0] PART_ID = 8'h3C; // Arbitrary
  localparam logic [7:0] REV_ID = 8'h07; // Arbitrary
  localparam logic [7:0] RW_SEL [9] = '{`SEL_DEVICE_CONTROL,
    `SEL_EPROM_PROGRAM_CONTROL, `SEL_EPROM_ADDRESS_LOW,
    `SEL_EPROM_ADDRESS_HIGH, `SEL_CHECKSUM_BYTE_0, `SEL_CHECKSUM_BYTE_1,
    `SEL_CHECKSUM_BYTE_2, `SEL_CHECKSUM_BYTE_3, `SEL_EPROM_DATA};
  logic clk_in, rst_in, ce_in, link_clk, dev_out, dev_oe, ad_out, ad_oe;
  logic halt, rd_p, wr_p, done, refused, wlock, rlock;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  wire logic line_lvl;
  int failures = 0;
  int cmp_count = 0;
  int wr_count = 0;
  int rd_count = 0;
  int wait_cnt = 0;

  // Released line is pulled low
  assign line_lvl = dev_oe ? dev_out : (ad_oe ? ad_out : 1'b0);

  debug_register_select #(.PART_IDENTITY(PART_ID),
    .SILICON_REVISION(REV_ID)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .debug_clock_line_in(link_clk), .debug_data_line_in(line_lvl),
    .debug_data_line_out(dev_out), .debug_data_line_oe_out(dev_oe),
    .halt_out(halt), .eprom_read_out(rd_p), .eprom_write_out(wr_p),
    .eprom_address_out(addr), .eprom_wdata_out(wdata),
    .eprom_done_in(done), .eprom_refused_in(refused),
    .eprom_rdata_in(rdata), .write_locked_flag_in(wlock),
    .read_locked_flag_in(rlock));

  debug_adapter_model i_adapter (.link_clk_out(link_clk),
    .data_out(ad_out), .data_oe_out(ad_oe), .line_in(line_lvl),
    .dev_oe_in(dev_oe));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // EPROM responder: one done pulse 200 cycles after each launch
  always @(negedge clk_in) begin
    done <= (wait_cnt == 1);
    if (wait_cnt > 0)
      wait_cnt--;
    if (wr_p === 1'b1 || rd_p === 1'b1)
      wait_cnt = 200;
    if (wr_p === 1'b1)
      wr_count++;
    if (rd_p === 1'b1)
      rd_count++;
  end

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic xfer(input debug_port_pkg::link_cmd_t cmd,
                      input logic [7:0] wd, output logic [7:0] rd);
    bit ok;
    i_adapter.frame(cmd, wd, rd, ok);
    if (!ok) begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic put(input logic [7:0] sel, input logic [7:0] v);
    logic [7:0] d;
    xfer(debug_port_pkg::CMD_ADDR_WRITE, sel, d);
    xfer(debug_port_pkg::CMD_DATA_WRITE, v, d);
  endtask

  task automatic get(input logic [7:0] sel, output logic [7:0] v);
    xfer(debug_port_pkg::CMD_ADDR_WRITE, sel, v);
    xfer(debug_port_pkg::CMD_DATA_READ, 8'h00, v);
  endtask

  task automatic poll_idle();
    logic [7:0] s;
    int n;
    s = 8'h80;
    n = 0;
    while (s[`BUSY_BIT] !== 1'b0 && n < 10) begin
      xfer(debug_port_pkg::CMD_ADDR_READ, 8'h00, s);
      n++;
    end
    `CHK("status idle", 8'h00, s)
    if (s !== 8'h00) begin
      wrap_up();
    end
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] v;
    `CHK("halt", 1'b0, halt)
    xfer(debug_port_pkg::CMD_DATA_READ, 8'h00, v);
    `CHK("identity", PART_ID, v)
    xfer(debug_port_pkg::CMD_ADDR_READ, 8'h00, v);
    `CHK("status", 8'h00, v)
  endtask

  task automatic t_readonly();
    logic [7:0] v;
    put(`SEL_PART_IDENTITY, 8'hFF);
    xfer(debug_port_pkg::CMD_DATA_READ, 8'h00, v);
    `CHK("identity", PART_ID, v)
    put(`SEL_SILICON_REVISION, 8'hFF);
    xfer(debug_port_pkg::CMD_DATA_READ, 8'h00, v);
    `CHK("revision", REV_ID, v)
    get(8'h55, v);
    `CHK("unmapped", 8'h00, v)
    xfer(debug_port_pkg::CMD_ADDR_READ, 8'h00, v);
    `CHK("status not select", 8'h00, v)
  endtask

  task automatic t_regs();
    logic [7:0] v;
    for (int i = 0; i < 9; i++) begin
      put(RW_SEL[i], {i[3:0], 4'h2});
    end
    for (int i = 0; i < 9; i++) begin
      get(RW_SEL[i], v);
      `CHK("data register", {i[3:0], 4'h2}, v)
    end
    `CHK("address", 16'h3222, addr)
    `CHK("write data", 8'h82, wdata)
    `CHK("no launch", 0, wr_count)
  endtask

  task automatic t_status();
    logic [7:0] v;
    @(negedge clk_in);
    wlock = 1'b1;
    put(`SEL_EPROM_STATUS, 8'hFF);
    xfer(debug_port_pkg::CMD_DATA_READ, 8'h00, v);
    `CHK("status locks", 8'h80, v)
    @(negedge clk_in);
    wlock = 1'b0;
    rlock = 1'b1;
    xfer(debug_port_pkg::CMD_DATA_READ, 8'h00, v);
    `CHK("status locks", 8'h40, v)
    @(negedge clk_in);
    rlock = 1'b0;
  endtask

  task automatic t_program();
    logic [7:0] v;
    put(`SEL_DEVICE_CONTROL, 8'h01);
    `CHK("halt", 1'b1, halt)
    put(`SEL_EPROM_PROGRAM_CONTROL, 8'h01);
    put(`SEL_EPROM_DATA, 8'hC3);
    xfer(debug_port_pkg::CMD_ADDR_READ, 8'h00, v);
    `CHK("busy", 8'h80, v)
    `CHK("write launch", 1, wr_count)
    `CHK("write data", 8'hC3, wdata)
    poll_idle();
    xfer(debug_port_pkg::CMD_DATA_READ, 8'h00, v);
    `CHK("data before read", 8'hC3, v)
    poll_idle();
    `CHK("read launch", 1, rd_count)
    xfer(debug_port_pkg::CMD_DATA_READ, 8'h00, v);
    `CHK("data read back", 8'hE7, v)
    poll_idle();
    @(negedge clk_in);
    refused = 1'b1;
    put(`SEL_EPROM_DATA, 8'h11);
    poll_idle();
    get(`SEL_EPROM_STATUS, v);
    `CHK("refused flag", 8'h01, v)
  endtask

  initial begin
    rst_in = 1'b1;
    ce_in = 1'b1;
    refused = 1'b0;
    rdata = 8'hE7;
    wlock = 1'b0;
    rlock = 1'b0;
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    t_reset();
    t_readonly();
    t_regs();
    t_status();
    t_program();
    wrap_up();
  end
endmodule // two_wire_debug_register_select_tb
